// file: pkg/guard_pkg.sv
/*
 constants shared by the line trigger guard: timing, register map, fields, states.
 assumes a single 100 MHz clock and 32-bit AXI4-Lite register access.
*/
package guard_pkg;
   // clock and time base
   localparam int CLK_PERIOD_NS = 10;
   localparam int TIME_BASE_NS = 100;
   localparam int TICK_CYCLES = TIME_BASE_NS / CLK_PERIOD_NS;
   // post-exposure dead time, default and with the limit removed (least times: round up)
   localparam int OVERHEAD_DEFAULT_NS = 5400;
   localparam int OVERHEAD_UNLIMITED_NS = 3400;
   localparam int OVERHEAD_DEFAULT_CYC = (OVERHEAD_DEFAULT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OVERHEAD_UNLIMITED_CYC = (OVERHEAD_UNLIMITED_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // overlap setting that matches the minimum line period
   localparam int MIN_LINE_PERIOD_NS = 12400;
   localparam int OVERLAP_DEFAULT_RAW = (MIN_LINE_PERIOD_NS - OVERHEAD_DEFAULT_NS) / TIME_BASE_NS;

   // register byte offsets
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_EXPOSURE = 8'h04;
   localparam logic [7:0] ADDR_READOUT = 8'h08;
   localparam logic [7:0] ADDR_OVERLAP = 8'h0c;
   localparam logic [7:0] ADDR_EVENTS = 8'h10;
   localparam logic [7:0] ADDR_MASK = 8'h14;
   localparam logic [7:0] ADDR_LIVE = 8'h18;

   // control fields
   localparam int CTRL_ENABLE = 0;
   localparam int CTRL_TRIG_WIDTH = 1;
   localparam int CTRL_FALLING = 2;
   localparam int CTRL_NO_LIMIT = 3;
   localparam int CTRL_W = 4;
   // event fields (status and mask share them)
   localparam int EV_START_OVT = 0;
   localparam int EV_END_OVT = 1;
   localparam int EV_ACCEPT = 2;
   localparam int EV_W = 3;

   // reset values
   localparam logic [3:0] CONTROL_RESET = 4'h0;
   localparam logic [15:0] EXPOSURE_RESET = 16'h0032;
   localparam logic [15:0] READOUT_RESET = 16'h0064;
   localparam logic [15:0] OVERLAP_RESET = 16'(OVERLAP_DEFAULT_RAW);
   localparam logic [2:0] MASK_RESET = 3'h0;

   // bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_EXPOSE = 2'b10
   } line_state_t;
endpackage

// file: hw/pin_sync_edge.sv
/*
 two-flop synchroniser for the trigger pin with start and end edge pulses.
 assumes the pin is asynchronous to aclk; edges come two cycles after the pin moves.
*/
`timescale 1ns/1ps
module pin_sync_edge (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic pin,
   input wire logic falling_active,
   output logic start_edge,
   output logic end_edge
);
   logic meta, level, level_d;
   logic rise, fall;

   // meta feeds only level; edges are taken from level and level_d
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta <= 1'b0;
         level <= 1'b0;
         level_d <= 1'b0;
      end
      else
      begin
         meta <= pin;
         level <= meta;
         level_d <= level;
      end
   end

   assign rise = level & ~level_d;
   assign fall = ~level & level_d;
   assign start_edge = falling_active ? fall : rise;
   assign end_edge = falling_active ? rise : fall;
endmodule

// file: hw/interval_timer.sv
/*
 loadable down counter measuring one interval in aclk cycles.
 assumes load_value is already scaled to cycles; busy while the count is not zero.
*/
`timescale 1ns/1ps
module interval_timer #(
   parameter int CNT_W = 20
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic load,
   input wire logic [CNT_W-1:0] load_value,
   output logic [CNT_W-1:0] remaining,
   output logic busy
);
   logic [CNT_W-1:0] next_remaining;

   // load wins over counting down
   always_comb
   begin
      next_remaining = remaining;
      if (load)
         next_remaining = load_value;
      else if (busy)
         next_remaining = remaining - CNT_W'(1);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         remaining <= '0;
      else
         remaining <= next_remaining;
   end

   assign busy = (remaining != '0);
endmodule

// file: hw/line_trigger_guard.sv
/*
 line start trigger guard: accepts or rejects external line start edges, times exposure,
 dead time and readout, flags overtriggers, AXI4-Lite register slave and interrupt.
 assumes one 100 MHz clock, synchronous active-low reset, a well-behaved AXI4-Lite master.
*/
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module line_trigger_guard #(
   parameter int RAW_W = 16,
   parameter int CNT_W = 20
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic external_line_start_trigger,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic awaiting_trigger,
   output logic exposure_active,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////////////////////////////////
   logic [guard_pkg::CTRL_W-1:0] control, next_control;
   logic [RAW_W-1:0] exposure_raw, next_exposure_raw, readout_raw, next_readout_raw;
   logic [RAW_W-1:0] overlap_raw, next_overlap_raw;
   logic [guard_pkg::EV_W-1:0] events, next_events, mask, next_mask, ev_set;
   logic aw_held, next_aw_held, w_held, next_w_held;
   logic [7:0] awaddr_q, next_awaddr_q;
   logic [31:0] wdata_q, next_wdata_q;
   logic [3:0] wstrb_q, next_wstrb_q;
   logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid, next_irq;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata, wr_word;
   guard_pkg::line_state_t state, next_state;
   logic next_awaiting, next_exposing;
   logic start_edge, end_edge, legal_start, end_now, load_exp, load_post;
   logic exp_busy, post_busy, ro_busy, readout_ok;
   logic [CNT_W-1:0] exp_left, post_left, ro_left, exp_cyc, post_cyc, ro_cyc, window_cyc;
   logic trig_width;

   assign trig_width = control[guard_pkg::CTRL_TRIG_WIDTH];

   // byte-lane merge of a write into a register image
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (s[i])
            r[8*i +: 8] = d[8*i +: 8];
      return r;
   endfunction

   // raw values in 100 ns units become cycle counts
   assign exp_cyc = (exposure_raw == '0) ? CNT_W'(1) :
                    CNT_W'(exposure_raw) * CNT_W'(guard_pkg::TICK_CYCLES);
   assign ro_cyc = CNT_W'(readout_raw) * CNT_W'(guard_pkg::TICK_CYCLES);
   assign post_cyc = control[guard_pkg::CTRL_NO_LIMIT] ? CNT_W'(guard_pkg::OVERHEAD_UNLIMITED_CYC) :
                     CNT_W'(guard_pkg::OVERHEAD_DEFAULT_CYC);
   assign window_cyc = trig_width ? CNT_W'(overlap_raw) * CNT_W'(guard_pkg::TICK_CYCLES) : exp_cyc;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // pin synchroniser and the three interval timers
   pin_sync_edge trig_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin(external_line_start_trigger),
      .falling_active(control[guard_pkg::CTRL_FALLING]),
      .start_edge(start_edge),
      .end_edge(end_edge)
   );

   interval_timer #(.CNT_W(CNT_W)) exp_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .load(load_exp),
      .load_value(exp_cyc),
      .remaining(exp_left),
      .busy(exp_busy)
   );

   interval_timer #(.CNT_W(CNT_W)) post_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .load(load_post),
      .load_value(post_cyc),
      .remaining(post_left),
      .busy(post_busy)
   );

   interval_timer #(.CNT_W(CNT_W)) readout_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .load(load_post),
      .load_value(ro_cyc),
      .remaining(ro_left),
      .busy(ro_busy)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // line acquisition sequencing; in trigger width mode a large overlap setting arms the wait output early
   assign legal_start = control[guard_pkg::CTRL_ENABLE] && (state == guard_pkg::ST_IDLE) && !post_busy;
   assign readout_ok = (ro_left <= window_cyc);

   always_comb
   begin
      next_state = state;
      ev_set = '0;
      load_exp = 1'b0;
      load_post = 1'b0;
      end_now = 1'b0;
      unique case (state)
         guard_pkg::ST_IDLE:
         begin
            if (start_edge && legal_start)
            begin
               next_state = guard_pkg::ST_EXPOSE;
               load_exp = !trig_width;
               ev_set[guard_pkg::EV_ACCEPT] = 1'b1;
            end
            else if (start_edge && control[guard_pkg::CTRL_ENABLE])
               ev_set[guard_pkg::EV_START_OVT] = 1'b1;
         end
         guard_pkg::ST_EXPOSE:
         begin
            if (trig_width)
            begin
               end_now = end_edge && !ro_busy;
               if (end_edge && ro_busy)
                  ev_set[guard_pkg::EV_END_OVT] = 1'b1;
            end
            else
               end_now = (exp_left == CNT_W'(1));
            if (start_edge)
               ev_set[guard_pkg::EV_START_OVT] = 1'b1;
            if (end_now)
            begin
               next_state = guard_pkg::ST_IDLE;
               load_post = 1'b1;
            end
         end
      endcase
      next_exposing = (next_state == guard_pkg::ST_EXPOSE);
      next_awaiting = (next_state == guard_pkg::ST_IDLE) && !load_post && !post_busy && readout_ok &&
                      control[guard_pkg::CTRL_ENABLE];
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state <= guard_pkg::ST_IDLE;
         exposure_active <= 1'b0;
         awaiting_trigger <= 1'b0;
      end
      else
      begin
         state <= next_state;
         exposure_active <= next_exposing;
         awaiting_trigger <= next_awaiting;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave, registers, sticky events and interrupt
   always_comb
   begin
      next_aw_held = aw_held;
      next_awaddr_q = awaddr_q;
      next_w_held = w_held;
      next_wdata_q = wdata_q;
      next_wstrb_q = wstrb_q;
      next_bvalid = s_axi_bvalid;
      next_bresp = s_axi_bresp;
      next_rvalid = s_axi_rvalid;
      next_rdata = s_axi_rdata;
      next_rresp = s_axi_rresp;
      next_control = control;
      next_exposure_raw = exposure_raw;
      next_readout_raw = readout_raw;
      next_overlap_raw = overlap_raw;
      next_mask = mask;
      next_events = events;
      wr_word = '0;
      if (s_axi_awvalid && s_axi_awready)
      begin
         next_aw_held = 1'b1;
         next_awaddr_q = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         next_w_held = 1'b1;
         next_wdata_q = s_axi_wdata;
         next_wstrb_q = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
         next_bvalid = 1'b0;
      // write once both halves are in and the previous answer is gone
      if (aw_held && w_held && !s_axi_bvalid)
      begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = guard_pkg::RESP_OKAY;
         case ({awaddr_q[7:2], 2'b00})
            guard_pkg::ADDR_CONTROL:
            begin
               wr_word = merge(32'(control), wdata_q, wstrb_q);
               next_control = wr_word[guard_pkg::CTRL_W-1:0];
            end
            guard_pkg::ADDR_EXPOSURE:
            begin
               wr_word = merge(32'(exposure_raw), wdata_q, wstrb_q);
               next_exposure_raw = wr_word[RAW_W-1:0];
            end
            guard_pkg::ADDR_READOUT:
            begin
               wr_word = merge(32'(readout_raw), wdata_q, wstrb_q);
               next_readout_raw = wr_word[RAW_W-1:0];
            end
            guard_pkg::ADDR_OVERLAP:
            begin
               wr_word = merge(32'(overlap_raw), wdata_q, wstrb_q);
               next_overlap_raw = wr_word[RAW_W-1:0];
            end
            guard_pkg::ADDR_EVENTS:
            begin
               wr_word = merge(32'h0, wdata_q, wstrb_q);
               next_events = events & ~wr_word[guard_pkg::EV_W-1:0];
            end
            guard_pkg::ADDR_MASK:
            begin
               wr_word = merge(32'(mask), wdata_q, wstrb_q);
               next_mask = wr_word[guard_pkg::EV_W-1:0];
            end
            guard_pkg::ADDR_LIVE: ;
            default: next_bresp = guard_pkg::RESP_SLVERR;
         endcase
      end
      // set wins over a clear in the same cycle
      next_events = next_events | ev_set;
      if (s_axi_rvalid && s_axi_rready)
         next_rvalid = 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
         next_rvalid = 1'b1;
         next_rresp = guard_pkg::RESP_OKAY;
         case ({s_axi_araddr[7:2], 2'b00})
            guard_pkg::ADDR_CONTROL: next_rdata = 32'(control);
            guard_pkg::ADDR_EXPOSURE: next_rdata = 32'(exposure_raw);
            guard_pkg::ADDR_READOUT: next_rdata = 32'(readout_raw);
            guard_pkg::ADDR_OVERLAP: next_rdata = 32'(overlap_raw);
            guard_pkg::ADDR_EVENTS: next_rdata = 32'(events);
            guard_pkg::ADDR_MASK: next_rdata = 32'(mask);
            guard_pkg::ADDR_LIVE: next_rdata = 32'({ro_busy, post_busy, exposure_active, awaiting_trigger});
            default:
            begin
               next_rdata = '0;
               next_rresp = guard_pkg::RESP_SLVERR;
            end
         endcase
      end
      next_awready = !next_aw_held && !next_bvalid;
      next_wready = !next_w_held && !next_bvalid;
      next_arready = !next_rvalid;
      next_irq = |(next_events & next_mask);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= guard_pkg::RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= guard_pkg::RESP_OKAY;
         control <= guard_pkg::CONTROL_RESET;
         exposure_raw <= guard_pkg::EXPOSURE_RESET;
         readout_raw <= guard_pkg::READOUT_RESET;
         overlap_raw <= guard_pkg::OVERLAP_RESET;
         mask <= guard_pkg::MASK_RESET;
         events <= '0;
         irq <= 1'b0;
      end
      else
      begin
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         awaddr_q <= next_awaddr_q;
         wdata_q <= next_wdata_q;
         wstrb_q <= next_wstrb_q;
         s_axi_awready <= next_awready;
         s_axi_wready <= next_wready;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         s_axi_arready <= next_arready;
         s_axi_rvalid <= next_rvalid;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
         control <= next_control;
         exposure_raw <= next_exposure_raw;
         readout_raw <= next_readout_raw;
         overlap_raw <= next_overlap_raw;
         mask <= next_mask;
         events <= next_events;
         irq <= next_irq;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // checks on the sequencing
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_illegal_no_start: assert property ((state == guard_pkg::ST_IDLE) && start_edge && !legal_start
      |=> (state == guard_pkg::ST_IDLE) && !exposure_active) else $error("illegal start accepted");
   a_illegal_flagged: assert property (start_edge && !legal_start && control[guard_pkg::CTRL_ENABLE]
      |=> events[guard_pkg::EV_START_OVT]) else $error("overtrigger not flagged");
   a_dead_time_blocks: assert property (post_busy && (state == guard_pkg::ST_IDLE)
      |=> state == guard_pkg::ST_IDLE) else $error("start inside dead time");
   a_early_end_held: assert property (trig_width && (state == guard_pkg::ST_EXPOSE) && end_edge && ro_busy
      |=> exposure_active && events[guard_pkg::EV_END_OVT]) else $error("early end not held");
   a_dead_time_len: assert property ($fell(exposure_active)
      |-> post_left == (control[guard_pkg::CTRL_NO_LIMIT] ? CNT_W'(guard_pkg::OVERHEAD_UNLIMITED_CYC)
                        : CNT_W'(guard_pkg::OVERHEAD_DEFAULT_CYC))) else $error("dead time length");
   a_timed_len: assert property ($rose(exposure_active) && !trig_width
      |-> exp_left == exp_cyc) else $error("timed exposure length");
   a_wait_drops: assert property ($rose(exposure_active) |-> !awaiting_trigger)
      else $error("awaiting still high in exposure");
   a_wait_only_idle: assert property (awaiting_trigger |-> state == guard_pkg::ST_IDLE && !exposure_active)
      else $error("awaiting outside idle");
   a_event_sticky: assert property (events[guard_pkg::EV_START_OVT] && !(aw_held && w_held)
      |=> events[guard_pkg::EV_START_OVT]) else $error("event lost");
   a_irq_follows: assert property (|(events & mask) && !(aw_held && w_held) |-> ##[0:1] irq)
      else $error("irq missing");

   c_line_accepted: cover property ($rose(exposure_active) ##[1:1000] $fell(exposure_active));
   c_start_overtrigger: cover property (start_edge && !legal_start && control[guard_pkg::CTRL_ENABLE]);
   c_early_end: cover property (trig_width && exposure_active && end_edge && ro_busy);
   c_irq_raised: cover property ($rose(irq));
endmodule

// file: verif/trig_source.sv
/*
 line start trigger source: drives the trigger pin with pulses of chosen width.
 assumes rising-edge activation, pin idle low, changes right after aclk edges.
*/
`timescale 1ns/1ps
module trig_source (
   input wire logic aclk,
   input wire logic awaiting_trigger,
   output logic pin
);
   initial pin = 1'b0;
   //////////////////////////////////////////////////////////////////////
   // one pulse: high hi cycles, low lo cycles; a polite source waits first
   // widths are the caller's; legal use keeps exposure >= 2 us and the period
   task automatic pulse(input int hi, input int lo, input bit polite);
      int n;
      n = 0;
      while (polite && awaiting_trigger !== 1'b1 && n < 2000)
      begin
         @(posedge aclk);
         n++;
      end
      @(posedge aclk);
      pin <= 1'b1;
      repeat (hi) @(posedge aclk);
      pin <= 1'b0;
      repeat (lo) @(posedge aclk);
   endtask
endmodule

// file: verif/tb_top.sv
/*
 self-checking bench for the line trigger guard: registers, accept, reject, timing.
 assumes the guard_pkg register map and the hand-over latencies; one 100 MHz clock.
*/
`timescale 1ns/1ps
module tb_top;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, irq, awaiting, exposing, pin;
   logic [1:0] bresp, rresp, rs;
   logic [31:0] rdata, rd;
   int mismatches = 0;
   int checks_done = 0;
   int cycles = 0;
   int n, t0;
   //////////////////////////////////////////////////////////////////////
   // clock and hang guard; ceiling is several times the expected run
   always #5 aclk = ~aclk;
   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         close_out();
      end
   end
   line_trigger_guard line_trigger_guard_i (
      .aclk(aclk),
      .aresetn(aresetn),
      .external_line_start_trigger(pin),
      .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid),
      .s_axi_awready(awready),
      .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid),
      .s_axi_wready(wready),
      .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid),
      .s_axi_bready(bready),
      .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid),
      .s_axi_arready(arready),
      .s_axi_rdata(rdata),
      .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid),
      .s_axi_rready(rready),
      .awaiting_trigger(awaiting),
      .exposure_active(exposing),
      .irq(irq)
   );
   trig_source trig_source_i (
      .aclk(aclk),
      .awaiting_trigger(awaiting),
      .pin(pin)
   );
   //////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
         mismatches++;
      end
   endtask
   // write: both channels offered at once, each dropped on its own ready
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      rs = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask
   // waits past the edge for exposing (sel 0) or awaiting (sel 1) to reach v
   task automatic wait_on(input bit sel, input logic v, output int c);
      c = 0;
      while ((sel ? awaiting : exposing) !== v && c < 3000)
      begin
         @(posedge aclk);
         #1;
         c++;
      end
   endtask
   //////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      rd_reg(guard_pkg::ADDR_CONTROL);
      check("control", 32'(guard_pkg::CONTROL_RESET), rd);
      rd_reg(guard_pkg::ADDR_EXPOSURE);
      check("exposure reg", 32'(guard_pkg::EXPOSURE_RESET), rd);
      rd_reg(guard_pkg::ADDR_READOUT);
      check("readout reg", 32'(guard_pkg::READOUT_RESET), rd);
      rd_reg(guard_pkg::ADDR_OVERLAP);
      check("overlap reg", 32'h46, rd);
      rd_reg(guard_pkg::ADDR_MASK);
      check("mask", 32'(guard_pkg::MASK_RESET), rd);
      rd_reg(8'h1c);
      check("unmapped rresp", 32'(guard_pkg::RESP_SLVERR), 32'(rs));
      check("unmapped rdata", 32'h0, rd);
      wr(8'h1c, 32'h1);
      check("unmapped bresp", 32'(guard_pkg::RESP_SLVERR), 32'(rs));
      $display("test regs done");
   endtask
   // disabled guard ignores edges and raises no event
   task automatic t_disabled();
      wr(guard_pkg::ADDR_CONTROL, 32'h0);
      trig_source_i.pulse(30, 30, 1'b0);
      rd_reg(guard_pkg::ADDR_EVENTS);
      check("disabled events", 32'h0, rd);
      $display("test disabled done");
   endtask
   // timed accept: raw 2 gives 20 cycles; readout 0 so dead time alone gates awaiting
   task automatic t_timed(input logic [31:0] ctrl, input int dead);
      wr(guard_pkg::ADDR_EVENTS, 32'h7);
      wr(guard_pkg::ADDR_CONTROL, ctrl);
      wr(guard_pkg::ADDR_EXPOSURE, 32'h2);
      wr(guard_pkg::ADDR_READOUT, 32'h0);
      fork
         trig_source_i.pulse(30, 0, 1'b1);
      join_none
      wait_on(1'b0, 1'b1, n);
      check("awaiting at start", 32'h0, 32'(awaiting));
      wait_on(1'b0, 1'b0, n);
      check("exposure cycles", 32'h14, n);
      wait_on(1'b1, 1'b1, n);
      check("dead time", 32'h1, 32'(n >= dead && n <= dead + 2));
      rd_reg(guard_pkg::ADDR_EVENTS);
      check("accept event", 32'h4, rd);
      $display("test timed done");
   endtask
   // edges during exposure and during dead time are dropped and flagged
   task automatic t_overtrig();
      wr(guard_pkg::ADDR_EVENTS, 32'h7);
      wr(guard_pkg::ADDR_EXPOSURE, 32'h32);
      fork
         trig_source_i.pulse(5, 0, 1'b1);
      join_none
      wait_on(1'b0, 1'b1, n);
      t0 = cycles;
      repeat (10) @(posedge aclk);
      trig_source_i.pulse(5, 5, 1'b0);
      wait_on(1'b0, 1'b0, n);
      check("no restart", 32'h1f4, 32'(cycles - t0));
      trig_source_i.pulse(5, 20, 1'b0);
      check("dead start", 32'h0, 32'(exposing));
      rd_reg(guard_pkg::ADDR_EVENTS);
      check("overtrigger flag", 32'h5, rd);
      check("irq masked", 32'h0, 32'(irq));
      wr(guard_pkg::ADDR_MASK, 32'h1);
      @(posedge aclk);
      check("irq raised", 32'h1, 32'(irq));
      wr(guard_pkg::ADDR_EVENTS, 32'h1);
      rd_reg(guard_pkg::ADDR_EVENTS);
      check("w1c", 32'h4, rd);
      check("irq cleared", 32'h0, 32'(irq));
      $display("test overtrigger done");
   endtask
   // trigger width: early end while readout busy is refused, exposure held
   task automatic t_width();
      wr(guard_pkg::ADDR_EVENTS, 32'h7);
      wr(guard_pkg::ADDR_MASK, 32'h0);
      wr(guard_pkg::ADDR_CONTROL, 32'h3);
      wr(guard_pkg::ADDR_READOUT, 32'h64);
      trig_source_i.pulse(30, 600, 1'b1);
      trig_source_i.pulse(40, 10, 1'b0);
      check("held on early end", 32'h1, 32'(exposing));
      rd_reg(guard_pkg::ADDR_EVENTS);
      check("early end flag", 32'h6, rd);
      repeat (400) @(posedge aclk);
      trig_source_i.pulse(5, 0, 1'b0);
      wait_on(1'b0, 1'b0, n);
      check("valid end", 32'h1, 32'(n < 10));
      $display("test width done");
   endtask
   // falling activation: the rise is an end edge and starts nothing, the fall starts
   task automatic t_falling();
      wr(guard_pkg::ADDR_CONTROL, 32'h5);
      wr(guard_pkg::ADDR_EXPOSURE, 32'h2);
      trig_source_i.pulse(10, 0, 1'b1);
      check("no start on rise", 32'h0, 32'(exposing));
      wait_on(1'b0, 1'b1, n);
      check("start on fall", 32'h1, 32'(n > 0 && n < 5));
      wait_on(1'b0, 1'b0, n);
      check("falling exposure", 32'h14, n);
      // dead time and readout both run right after the exposure ends
      rd_reg(guard_pkg::ADDR_LIVE);
      check("live after end", 32'hc, rd);
      $display("test falling done");
   endtask
   //////////////////////////////////////////////////////////////////////
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // main sequence; first bus request well after the reset release
   initial
   begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      t_regs();
      t_disabled();
      t_timed(32'h1, guard_pkg::OVERHEAD_DEFAULT_CYC);
      t_timed(32'h9, guard_pkg::OVERHEAD_UNLIMITED_CYC);
      t_overtrig();
      t_width();
      t_falling();
      close_out();
   end
endmodule
